// ==== hw/hot_swap_fault.v ====
/*
 Hot-swap fault sequencing, sticky status, alert output and SMBus
 status slave. Assumes analog comparators deliver clean levels
 synchronous to CLK, and that straps are stable when NRST releases.
*/
`timescale 1ns/1ps
`include "hot_swap_fault_defs.vh"

module hot_swap_fault #(
   parameter [6:0] SLAVE_ADDR         = 7'h40,
   parameter       DELAY_W            = 8,
   parameter [7:0] FAULT_DELAY_CYCLES = `FAULT_GATE_DELAY_CYC
) (
   input  wire       CLK,
   input  wire       NRST,
   input  wire       LIMIT_THRESHOLD_SELECT,
   input  wire       BREAKER_STRAP,
   input  wire [2:0] RETRY_STRAP,
   input  wire       POR_OK,
   input  wire       UNDERVOLTAGE_ENABLE_INPUT,
   input  wire       OVERVOLTAGE_LOCKOUT_INPUT,
   input  wire       CURRENT_LIMIT_ACTIVE,
   input  wire       POWER_LIMIT_ACTIVE,
   input  wire       BREAKER_TRIP,
   input  wire       TIMER_AT_UPPER,
   input  wire       SCL,
   input  wire       SDA_I,
   output wire       SDA_O,
   output wire       SDA_OE,
   output wire       ALERT_OUT_N_O,
   output wire       ALERT_OUT_N_OE,
   output reg        LIMIT_THRESHOLD_26MV,
   output reg        BREAKER_CONFIG_SEL,
   output wire       GATE_ENABLE,
   output wire       GATE_FAST_PULLDOWN,
   output wire       GATE_SLOW_PULLDOWN,
   output wire       TIMER_CHARGE,
   output wire       TIMER_DISCHARGE
);

   localparam [6:0] ST_POR    = 7'h01;
   localparam [6:0] ST_INSERT = 7'h02;
   localparam [6:0] ST_WAIT   = 7'h04;
   localparam [6:0] ST_ON     = 7'h08;
   localparam [6:0] ST_FDELAY = 7'h10;
   localparam [6:0] ST_OFF    = 7'h20;
   localparam [6:0] ST_RETRY  = 7'h40;

   localparam [4:0] PH_IDLE  = 5'h01;
   localparam [4:0] PH_ADDR  = 5'h02;
   localparam [4:0] PH_CMD   = 5'h04;
   localparam [4:0] PH_WDATA = 5'h08;
   localparam [4:0] PH_READ  = 5'h10;

   reg  [6:0]         state;
   reg  [6:0]         next_state;
   reg  [DELAY_W-1:0] delay_cnt;
   reg  [4:0]         retry_cnt;
   reg                powered_up;
   reg                straps_taken;
   reg                strap_lim;
   reg                strap_cb;
   reg  [2:0]         strap_retry;
   reg                uv_q;
   reg                ov_q;
   reg                trip_q;
   reg                oc_flag;
   reg                uv_flag;
   reg                ov_flag;
   reg                cb_flag;
   reg  [15:0]        alert_mask;
   reg  [7:0]         pin_setup;
   reg  [4:0]         phase;
   reg  [3:0]         bitcnt;
   reg  [7:0]         shreg;
   reg  [7:0]         txsh;
   reg  [7:0]         cmd;
   reg                byte_idx;
   reg                rw_read;
   reg                addr_hit;
   reg                sda_drive;
   reg                scl_q;
   reg                sda_q;
   reg                clear_pulse;
   reg  [15:0]        rd_word;
   wire               limiting;
   wire               run_ok;
   wire               oc_event;
   wire               uv_event;
   wire               ov_event;
   wire               cb_event;
   wire               retry_allowed;
   wire [4:0]         retry_limit;
   wire [3:0]         masked_src;
   wire               scl_rise;
   wire               scl_fall;
   wire               start_cond;
   wire               stop_cond;
   wire [7:0]         rd_byte;

   // Straps sampled once after reset release, never under the reset itself
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         straps_taken <= 1'b0;
         strap_lim    <= 1'b0;
         strap_cb     <= 1'b0;
         strap_retry  <= 3'h0;
      end else if (!straps_taken) begin
         straps_taken <= 1'b1;
         strap_lim    <= LIMIT_THRESHOLD_SELECT;
         strap_cb     <= BREAKER_STRAP;
         strap_retry  <= RETRY_STRAP;
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         LIMIT_THRESHOLD_26MV <= 1'b0;
         BREAKER_CONFIG_SEL   <= 1'b0;
      end else begin
         if (pin_setup[`SETUP_LIM_OVR_BIT])
            LIMIT_THRESHOLD_26MV <= pin_setup[`SETUP_LIM_VAL_BIT];
         else
            LIMIT_THRESHOLD_26MV <= strap_lim;
         if (pin_setup[`SETUP_CB_OVR_BIT])
            BREAKER_CONFIG_SEL <= pin_setup[`SETUP_CB_VAL_BIT];
         else
            BREAKER_CONFIG_SEL <= strap_cb;
      end
   end

   // Breaker counts as limiting so its timeout is qualified alike
   assign limiting = CURRENT_LIMIT_ACTIVE | POWER_LIMIT_ACTIVE
                     | BREAKER_TRIP;
   assign run_ok   = UNDERVOLTAGE_ENABLE_INPUT & ~OVERVOLTAGE_LOCKOUT_INPUT;

   // Code 0 latches off, 6 and 7 retry forever
   assign retry_limit   = (strap_retry == 3'h0) ? 5'h00
                        : (5'h01 << (strap_retry - 3'h1));
   assign retry_allowed = (strap_retry[2] & strap_retry[1])
                        | (retry_cnt < retry_limit);

   always @* begin
      next_state = state;
      case (state)
         ST_POR:
            if (POR_OK)
               next_state = ST_INSERT;
         ST_INSERT:
            if (TIMER_AT_UPPER)
               next_state = ST_WAIT;
         ST_WAIT:
            if (run_ok && !TIMER_AT_UPPER)
               next_state = ST_ON;
         ST_ON:
            if (!run_ok)
               next_state = ST_WAIT;
            else if (limiting && TIMER_AT_UPPER)
               next_state = ST_FDELAY;
         ST_FDELAY:
            if (delay_cnt == FAULT_DELAY_CYCLES - 8'h01)
               next_state = retry_allowed ? ST_RETRY : ST_OFF;
         ST_OFF:
            if (!UNDERVOLTAGE_ENABLE_INPUT)
               next_state = ST_WAIT;
         ST_RETRY:
            if (TIMER_AT_UPPER)
               next_state = ST_WAIT;
         default:
            next_state = ST_POR;
      endcase
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state      <= ST_POR;
         delay_cnt  <= {DELAY_W{1'b0}};
         retry_cnt  <= 5'h00;
         powered_up <= 1'b0;
      end else begin
         state <= next_state;
         if (state == ST_FDELAY)
            delay_cnt <= delay_cnt + 1'b1;
         else
            delay_cnt <= {DELAY_W{1'b0}};
         if (state == ST_OFF && next_state == ST_WAIT)
            retry_cnt <= 5'h00;
         else if (state == ST_RETRY && next_state == ST_WAIT
                  && retry_cnt != 5'h1F)
            retry_cnt <= retry_cnt + 5'h01;
         if (state == ST_ON)
            powered_up <= 1'b1;
      end
   end

   assign GATE_ENABLE        = state[3] | state[4];
   // Fast pulldown follows the comparator so the limiter regains control
   assign GATE_FAST_PULLDOWN = state[0]
                             | (GATE_ENABLE & BREAKER_TRIP);
   assign GATE_SLOW_PULLDOWN = ~GATE_ENABLE & ~state[0];
   // Recovery before timeout simply discharges the timer again
   assign TIMER_CHARGE       = state[1] | state[6]
                             | (state[3] & limiting);
   assign TIMER_DISCHARGE    = ~TIMER_CHARGE;

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         uv_q   <= 1'b0;
         ov_q   <= 1'b0;
         trip_q <= 1'b0;
      end else begin
         uv_q   <= UNDERVOLTAGE_ENABLE_INPUT;
         ov_q   <= OVERVOLTAGE_LOCKOUT_INPUT;
         trip_q <= BREAKER_TRIP;
      end
   end

   assign oc_event = state[3] & (next_state == ST_FDELAY);
   assign uv_event = powered_up & uv_q
                   & ~UNDERVOLTAGE_ENABLE_INPUT;
   assign ov_event = straps_taken & ~ov_q
                   & OVERVOLTAGE_LOCKOUT_INPUT;
   assign cb_event = GATE_ENABLE & ~trip_q & BREAKER_TRIP;

   // Set beats a clear arriving in the same cycle
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         oc_flag <= 1'b0;
         uv_flag <= 1'b0;
         ov_flag <= 1'b0;
         cb_flag <= 1'b0;
      end else begin
         oc_flag <= oc_event | (oc_flag & ~clear_pulse);
         uv_flag <= uv_event | (uv_flag & ~clear_pulse);
         ov_flag <= ov_event | (ov_flag & ~clear_pulse);
         cb_flag <= cb_event | (cb_flag & ~clear_pulse);
      end
   end

   assign masked_src = {cb_flag & ~alert_mask[`MASK_CB_BIT],
                        ov_flag & ~alert_mask[`MASK_OV_BIT],
                        uv_flag & ~alert_mask[`MASK_UV_BIT],
                        oc_flag & ~alert_mask[`MASK_OC_BIT]};
   assign ALERT_OUT_N_O  = 1'b0;
   assign ALERT_OUT_N_OE = |masked_src;

   always @* begin
      rd_word = 16'h0000;
      case (cmd)
         `CMD_SUMMARY_STATUS:
            rd_word[`SUM_INPUT_BIT] = oc_flag | uv_flag | ov_flag;
         `CMD_INPUT_STATUS: begin
            rd_word[`IN_OV_BIT] = ov_flag;
            rd_word[`IN_UV_BIT] = uv_flag;
            rd_word[`IN_OC_BIT] = oc_flag;
         end
         `CMD_OTHER_STATUS:
            rd_word[`OTHER_CB_BIT] = cb_flag;
         `CMD_VENDOR_STATUS:
            rd_word[`VENDOR_CB_BIT] = cb_flag;
         `CMD_ALERT_MASK:
            rd_word = alert_mask;
         `CMD_PIN_OVERRIDE:
            rd_word = {8'h00, pin_setup};
         `CMD_DIAGNOSTICS: begin
            rd_word[`DIAG_OC_BIT] = oc_flag;
            rd_word[`DIAG_OV_BIT] = ov_flag;
            rd_word[`DIAG_UV_BIT] = uv_flag;
            rd_word[`DIAG_CB_BIT] = cb_flag;
         end
         default:
            rd_word = 16'h0000;
      endcase
   end

   // Words go low byte first
   assign rd_byte    = byte_idx ? rd_word[15:8] : rd_word[7:0];
   assign scl_rise   = ~scl_q & SCL;
   assign scl_fall   = scl_q & ~SCL;
   assign start_cond = SCL & scl_q & sda_q & ~SDA_I;
   assign stop_cond  = SCL & scl_q & ~sda_q & SDA_I;
   assign SDA_O      = 1'b0;
   assign SDA_OE     = sda_drive;

   // No clock stretching; the host must honour standard SMBus timing
   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         scl_q       <= 1'b1;
         sda_q       <= 1'b1;
         phase       <= PH_IDLE;
         bitcnt      <= 4'h0;
         shreg       <= 8'h00;
         txsh        <= 8'h00;
         cmd         <= 8'h00;
         byte_idx    <= 1'b0;
         rw_read     <= 1'b0;
         addr_hit    <= 1'b0;
         sda_drive   <= 1'b0;
         clear_pulse <= 1'b0;
         alert_mask  <= `ALERT_MASK_RESET;
         pin_setup   <= `PIN_OVERRIDE_RESET;
      end else begin
         scl_q       <= SCL;
         sda_q       <= SDA_I;
         clear_pulse <= 1'b0;
         if (start_cond) begin
            phase     <= PH_ADDR;
            bitcnt    <= 4'h0;
            sda_drive <= 1'b0;
         end else if (stop_cond) begin
            phase     <= PH_IDLE;
            sda_drive <= 1'b0;
         end else if (phase != PH_IDLE) begin
            if (scl_rise && bitcnt != 4'h9) begin
               shreg  <= {shreg[6:0], SDA_I};
               bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall) begin
               case (bitcnt)
                  4'h8: begin
                     case (phase)
                        PH_ADDR: begin
                           addr_hit  <= (shreg[7:1] == SLAVE_ADDR);
                           rw_read   <= shreg[0];
                           sda_drive <= (shreg[7:1] == SLAVE_ADDR);
                        end
                        PH_CMD: begin
                           cmd       <= shreg;
                           byte_idx  <= 1'b0;
                           sda_drive <= 1'b1;
                           if (shreg == `CMD_CLEAR_FAULTS)
                              clear_pulse <= 1'b1;
                        end
                        PH_WDATA: begin
                           sda_drive <= 1'b1;
                           if (cmd == `CMD_ALERT_MASK && !byte_idx)
                              alert_mask[7:0] <= shreg;
                           if (cmd == `CMD_ALERT_MASK && byte_idx)
                              alert_mask[15:8] <= shreg;
                           if (cmd == `CMD_PIN_OVERRIDE && !byte_idx)
                              pin_setup <= shreg;
                        end
                        default:
                           sda_drive <= 1'b0;
                     endcase
                  end
                  4'h9: begin
                     bitcnt <= 4'h0;
                     case (phase)
                        PH_ADDR:
                           if (!addr_hit) begin
                              phase     <= PH_IDLE;
                              sda_drive <= 1'b0;
                           end else if (rw_read) begin
                              phase     <= PH_READ;
                              byte_idx  <= 1'b0;
                              txsh      <= rd_word[7:0];
                              sda_drive <= ~rd_word[7];
                           end else begin
                              phase     <= PH_CMD;
                              sda_drive <= 1'b0;
                           end
                        PH_CMD: begin
                           phase     <= PH_WDATA;
                           sda_drive <= 1'b0;
                        end
                        PH_WDATA: begin
                           byte_idx  <= 1'b1;
                           sda_drive <= 1'b0;
                        end
                        PH_READ:
                           if (shreg[0]) begin
                              phase     <= PH_IDLE;
                              sda_drive <= 1'b0;
                           end else begin
                              byte_idx  <= 1'b1;
                              txsh      <= rd_word[15:8];
                              sda_drive <= ~rd_word[15];
                           end
                        default:
                           phase <= PH_IDLE;
                     endcase
                  end
                  default:
                     if (phase == PH_READ) begin
                        txsh      <= {txsh[6:0], 1'b0};
                        sda_drive <= ~txsh[6];
                     end
               endcase
            end
         end
      end
   end

endmodule // hot_swap_fault

// ==== hw/hot_swap_fault_defs.vh ====
/*
 Constants for the hot-swap fault sequencing and status logic: register
 command codes, status field positions, reset values and timing counts.
 Assumes a 20 MHz core clock and an SMBus host reading status words.
*/
`ifndef HOT_SWAP_FAULT_DEFS_VH
`define HOT_SWAP_FAULT_DEFS_VH

// Command codes
`define CMD_CLEAR_FAULTS     8'h03
`define CMD_SUMMARY_STATUS   8'h79
`define CMD_INPUT_STATUS     8'h7C
`define CMD_OTHER_STATUS     8'h7F
`define CMD_VENDOR_STATUS    8'h80
`define CMD_ALERT_MASK       8'hD8
`define CMD_PIN_OVERRIDE     8'hD9
`define CMD_DIAGNOSTICS      8'hE1

// Field positions
`define SUM_INPUT_BIT        13
`define IN_OV_BIT            7
`define IN_UV_BIT            4
`define IN_OC_BIT            2
`define OTHER_CB_BIT         1
`define VENDOR_CB_BIT        1
`define DIAG_OC_BIT          8
`define DIAG_OV_BIT          7
`define DIAG_UV_BIT          6
`define DIAG_CB_BIT          4
`define MASK_OC_BIT          0
`define MASK_UV_BIT          1
`define MASK_OV_BIT          2
`define MASK_CB_BIT          3
`define SETUP_LIM_OVR_BIT    0
`define SETUP_LIM_VAL_BIT    1
`define SETUP_CB_OVR_BIT     2
`define SETUP_CB_VAL_BIT     3

// Reset values
`define ALERT_MASK_RESET     16'h0000
`define PIN_OVERRIDE_RESET   8'h00

// Timing
`define CLK_PERIOD_NS        50
`define FAULT_GATE_DELAY_NS  12000
// Delay in clocks, sized for the 8-bit delay parameter
`define FAULT_GATE_DELAY_CYC 8'hF0

`endif

// ==== hw/unused_placeholder_none.v ====
`timescale 1ns/1ps

// ==== verif/hot_swap_fault_assertions.sv ====
/*
 Checker for the hot-swap fault block: gate, timer and alert relations.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module hot_swap_fault_assertions #(
   parameter [7:0] FAULT_DELAY_CYCLES = 8'hF0
) (
   input wire CLK,
   input wire NRST,
   input wire POR_OK,
   input wire UNDERVOLTAGE_ENABLE_INPUT,
   input wire OVERVOLTAGE_LOCKOUT_INPUT,
   input wire CURRENT_LIMIT_ACTIVE,
   input wire POWER_LIMIT_ACTIVE,
   input wire BREAKER_TRIP,
   input wire TIMER_AT_UPPER,
   input wire ALERT_OUT_N_OE,
   input wire GATE_ENABLE,
   input wire GATE_FAST_PULLDOWN,
   input wire GATE_SLOW_PULLDOWN,
   input wire TIMER_CHARGE
);
   reg  [7:0] dly;
   wire       limiting;
   wire       entry;
   assign limiting = CURRENT_LIMIT_ACTIVE | POWER_LIMIT_ACTIVE | BREAKER_TRIP;
   // Charging with gate on only in the running state, so no retrigger
   assign entry = GATE_ENABLE & TIMER_CHARGE & limiting & TIMER_AT_UPPER
                  & (dly == 8'h00);
   always @(posedge CLK or negedge NRST) begin
      if (!NRST)
         dly <= 8'h00;
      else if (entry)
         dly <= 8'h01;
      else if (dly != 8'h00 && dly < FAULT_DELAY_CYCLES)
         dly <= dly + 8'h01;
      else
         dly <= 8'h00;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   sequence in_delay;
      dly != 8'h00;
   endsequence
   sequence delay_done;
      dly == FAULT_DELAY_CYCLES;
   endsequence
   chk_fault_hold_gate: assert property (in_delay |-> GATE_ENABLE)
      else $error("gate dropped inside fault delay");
   chk_fault_gate_off: assert property (delay_done |=> !GATE_ENABLE
      && GATE_SLOW_PULLDOWN) else $error("gate not off after fault delay");
   chk_breaker_fast_pd: assert property (GATE_ENABLE && BREAKER_TRIP
      |-> GATE_FAST_PULLDOWN && TIMER_CHARGE) else $error("no fast pulldown");
   chk_breaker_release: assert property (GATE_ENABLE && !BREAKER_TRIP
      |-> !GATE_FAST_PULLDOWN) else $error("fast pulldown kept");
   chk_limit_timer_run: assert property ($rose(CURRENT_LIMIT_ACTIVE
      || POWER_LIMIT_ACTIVE) && GATE_ENABLE && !TIMER_AT_UPPER
      |-> TIMER_CHARGE) else $error("timer idle while limiting");
   chk_gate_needs_en: assert property ($rose(GATE_ENABLE) |->
      $past(UNDERVOLTAGE_ENABLE_INPUT && !OVERVOLTAGE_LOCKOUT_INPUT && POR_OK))
      else $error("gate on without enable");
   chk_ov_gate_off: assert property (OVERVOLTAGE_LOCKOUT_INPUT && GATE_ENABLE
      && !limiting && dly == 8'h00 |=> !GATE_ENABLE)
      else $error("gate on during overvoltage");
   chk_slow_pd_off: assert property (GATE_SLOW_PULLDOWN ==
      (!GATE_ENABLE && !GATE_FAST_PULLDOWN)) else $error("slow pulldown");
   chk_alert_has_cause: assert property ($rose(ALERT_OUT_N_OE) |->
      $past(TIMER_AT_UPPER || BREAKER_TRIP || !UNDERVOLTAGE_ENABLE_INPUT
      || OVERVOLTAGE_LOCKOUT_INPUT)) else $error("alert without event");
endmodule // hot_swap_fault_assertions

// ==== verif/hot_swap_fault_tb.sv ====
/*
 Self-checking bench for the hot-swap fault block, with SMBus host model.
 Assumes the defs header on the include path; drives on falling edges.
*/
`timescale 1ns/1ps
`include "hot_swap_fault_defs.vh"
module hot_swap_fault_tb;
   localparam [7:0] FD = 8'h08;
   reg  clk, nrst, lsel, bstrap, por, uven, ov, ilim, pl, trip, tup;
   reg  [2:0]  retry;
   reg  [15:0] d;
   reg         ok;
   wire scl, pull, sda, sda_o, sda_oe, al_o, al_oe, lim26, bsel;
   wire gate, fpd, spd, tch, tdis, alert_n;
   integer n_errors, num_checks, i;
   assign sda = ~((sda_oe & ~sda_o) | pull);
   assign alert_n = ~(al_oe & ~al_o);
   hot_swap_fault #(.FAULT_DELAY_CYCLES(FD)) uut (.CLK(clk), .NRST(nrst),
      .LIMIT_THRESHOLD_SELECT(lsel), .BREAKER_STRAP(bstrap),
      .RETRY_STRAP(retry), .POR_OK(por), .UNDERVOLTAGE_ENABLE_INPUT(uven),
      .OVERVOLTAGE_LOCKOUT_INPUT(ov), .CURRENT_LIMIT_ACTIVE(ilim),
      .POWER_LIMIT_ACTIVE(pl), .BREAKER_TRIP(trip), .TIMER_AT_UPPER(tup),
      .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .ALERT_OUT_N_O(al_o), .ALERT_OUT_N_OE(al_oe),
      .LIMIT_THRESHOLD_26MV(lim26), .BREAKER_CONFIG_SEL(bsel),
      .GATE_ENABLE(gate), .GATE_FAST_PULLDOWN(fpd), .GATE_SLOW_PULLDOWN(spd),
      .TIMER_CHARGE(tch), .TIMER_DISCHARGE(tdis));
   smbus_host_model host (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task cyc(input integer n);
      repeat (n) @(negedge clk);
   endtask
   task close_out;
      begin
         if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task rdc(input [7:0] cmd, input integer nb, input [15:0] exp);
      begin
         host.rd(cmd, nb, d, ok);
         chk(ok, 1'b1);
         chk(d, exp);
      end
   endtask
   task wrc(input [7:0] cmd, input [15:0] v, input integer nb);
      begin
         host.wr(cmd, v, nb, ok);
         chk(ok, 1'b1);
      end
   endtask
   task reset_dut(input l, input [2:0] r);
      begin
         nrst = 1'b0; lsel = l; bstrap = 1'b0; retry = r; por = 1'b0;
         uven = 1'b0; ov = 1'b0; ilim = 1'b0; pl = 1'b0; trip = 1'b0;
         tup = 1'b0;
         cyc(16);
         chk({gate, fpd, tdis}, 3'h3);
         nrst = 1'b1;
         cyc(3);
         chk(lim26, l);
      end
   endtask
   task bring_up;
      begin
         por = 1'b1; uven = 1'b1;
         cyc(4);
         chk({gate, tch}, 2'h1);
         tup = 1'b1;
         cyc(1);
         tup = 1'b0;
         cyc(4);
         chk(gate, 1'b1);
      end
   endtask
   task timeout(input use_pl);
      begin
         ilim = !use_pl; pl = use_pl;
         cyc(3);
         chk({gate, tch}, 2'h3);
         tup = 1'b1;
         cyc(1);
         tup = 1'b0;
         for (i = 0; i < FD + 20 && gate === 1'b1; i = i + 1) cyc(1);
         if (gate !== 1'b0) begin
            n_errors = n_errors + 1;
            close_out;
         end
         chk(spd, 1'b1);
         ilim = 1'b0; pl = 1'b0;
      end
   endtask
   task recover;
      begin
         uven = 1'b0;
         cyc(3);
         chk(alert_n, 1'b0);
         uven = 1'b1;
         cyc(4);
         chk(gate, 1'b1);
         wrc(`CMD_CLEAR_FAULTS, 16'h0000, 0);
         chk(alert_n, 1'b1);
      end
   endtask
   task s_reset_regs;
      begin
         rdc(`CMD_ALERT_MASK, 2, `ALERT_MASK_RESET);
         rdc(`CMD_PIN_OVERRIDE, 1, `PIN_OVERRIDE_RESET);
         rdc(`CMD_INPUT_STATUS, 1, 16'h0000);
         rdc(8'h55, 1, 16'h0000);
      end
   endtask
   task s_short_limit;
      begin
         ilim = 1'b1;
         cyc(10);
         ilim = 1'b0;
         cyc(3);
         chk({gate, alert_n}, 2'h3);
         rdc(`CMD_INPUT_STATUS, 1, 16'h0000);
      end
   endtask
   task s_cl_timeout;
      begin
         timeout(1'b0);
         chk(alert_n, 1'b0);
         cyc(20);
         chk(gate, 1'b0);
         rdc(`CMD_INPUT_STATUS, 1, 16'h0004);
         host.rd(`CMD_SUMMARY_STATUS, 2, d, ok);
         chk(d[`SUM_INPUT_BIT], 1'b1);
         host.rd(`CMD_DIAGNOSTICS, 2, d, ok);
         chk(d[`DIAG_OC_BIT], 1'b1);
         wrc(`CMD_CLEAR_FAULTS, 16'h0000, 0);
         rdc(`CMD_INPUT_STATUS, 1, 16'h0000);
         uven = 1'b0;
         cyc(3);
         rdc(`CMD_INPUT_STATUS, 1, 16'h0010);
         host.rd(`CMD_DIAGNOSTICS, 2, d, ok);
         chk({d[`DIAG_UV_BIT], gate}, 2'h2);
         uven = 1'b1;
         cyc(4);
         wrc(`CMD_CLEAR_FAULTS, 16'h0000, 0);
      end
   endtask
   task s_pl_masked;
      begin
         wrc(`CMD_ALERT_MASK, 16'h0001, 2);
         rdc(`CMD_ALERT_MASK, 2, 16'h0001);
         timeout(1'b1);
         chk(alert_n, 1'b1);
         rdc(`CMD_INPUT_STATUS, 1, 16'h0004);
         recover;
      end
   endtask
   task s_breaker;
      begin
         trip = 1'b1;
         cyc(1);
         chk({fpd, tch}, 2'h3);
         cyc(1);
         trip = 1'b0;
         cyc(1);
         chk({fpd, gate, alert_n}, 3'h2);
         rdc(`CMD_OTHER_STATUS, 1, 16'h0002);
         host.rd(`CMD_VENDOR_STATUS, 1, d, ok);
         chk(d[`VENDOR_CB_BIT], 1'b1);
         host.rd(`CMD_DIAGNOSTICS, 2, d, ok);
         chk(d[`DIAG_CB_BIT], 1'b1);
         wrc(`CMD_CLEAR_FAULTS, 16'h0000, 0);
      end
   endtask
   task s_ov;
      begin
         ov = 1'b1;
         cyc(3);
         chk({gate, alert_n}, 2'h0);
         ov = 1'b0;
         cyc(4);
         chk(gate, 1'b1);
         rdc(`CMD_INPUT_STATUS, 1, 16'h0080);
         host.rd(`CMD_DIAGNOSTICS, 2, d, ok);
         chk(d[`DIAG_OV_BIT], 1'b1);
         host.rd(`CMD_SUMMARY_STATUS, 2, d, ok);
         chk(d[`SUM_INPUT_BIT], 1'b1);
         wrc(`CMD_CLEAR_FAULTS, 16'h0000, 0);
      end
   endtask
   task s_override;
      begin
         wrc(`CMD_PIN_OVERRIDE, 16'h000F, 1);
         cyc(3);
         chk({lim26, bsel}, 2'h3);
         wrc(`CMD_PIN_OVERRIDE, 16'h000A, 1);
         cyc(3);
         chk({lim26, bsel}, 2'h0);
      end
   endtask
   task s_retry_once;
      begin
         timeout(1'b0);
         chk(tch, 1'b1);
         tup = 1'b1;
         cyc(1);
         tup = 1'b0;
         cyc(4);
         chk(gate, 1'b1);
         timeout(1'b0);
         cyc(3);
         chk({gate, tch}, 2'h0);
      end
   endtask
   initial begin
      n_errors = 0;
      num_checks = 0;
      reset_dut(1'b1, 3'h0);
      s_reset_regs;
      bring_up;
      s_short_limit;
      s_cl_timeout;
      s_pl_masked;
      s_breaker;
      s_ov;
      reset_dut(1'b0, 3'h1);
      s_override;
      bring_up;
      s_retry_once;
      close_out;
   end
endmodule // hot_swap_fault_tb
bind hot_swap_fault hot_swap_fault_assertions #(
   .FAULT_DELAY_CYCLES(FAULT_DELAY_CYCLES)) chk_i (.CLK(CLK), .NRST(NRST),
   .POR_OK(POR_OK), .UNDERVOLTAGE_ENABLE_INPUT(UNDERVOLTAGE_ENABLE_INPUT),
   .OVERVOLTAGE_LOCKOUT_INPUT(OVERVOLTAGE_LOCKOUT_INPUT),
   .CURRENT_LIMIT_ACTIVE(CURRENT_LIMIT_ACTIVE),
   .POWER_LIMIT_ACTIVE(POWER_LIMIT_ACTIVE), .BREAKER_TRIP(BREAKER_TRIP),
   .TIMER_AT_UPPER(TIMER_AT_UPPER), .ALERT_OUT_N_OE(ALERT_OUT_N_OE),
   .GATE_ENABLE(GATE_ENABLE), .GATE_FAST_PULLDOWN(GATE_FAST_PULLDOWN),
   .GATE_SLOW_PULLDOWN(GATE_SLOW_PULLDOWN), .TIMER_CHARGE(TIMER_CHARGE));

// ==== verif/smbus_host_model.sv ====
/*
 SMBus host model: byte writes and word reads with ACK reporting.
 Assumes SDA is a pulled-up wire resolved by the testbench.
*/
`timescale 1ns/1ps
module smbus_host_model #(
   parameter [6:0] ADDR = 7'h40
) (
   input  wire clk,
   input  wire sda,
   output reg  scl,
   output reg  pull
);
   initial begin
      scl  = 1'b1;
      pull = 1'b0;
   end
   task q;
      repeat (4) @(negedge clk);
   endtask
   task bit_io(input b, output r);
      begin
         pull = !b;
         q;
         scl = 1'b1;
         q;
         r = sda;
         q;
         scl = 1'b0;
         q;
      end
   endtask
   // Also serves as repeated start, since SCL is low between bytes
   task start;
      begin
         pull = 1'b0;
         q;
         scl = 1'b1;
         q;
         pull = 1'b1;
         q;
         scl = 1'b0;
         q;
      end
   endtask
   task stop;
      begin
         pull = 1'b1;
         q;
         scl = 1'b1;
         q;
         pull = 1'b0;
         q;
      end
   endtask
   task byte_io(input [7:0] d, input m, output [7:0] r, output a);
      integer i;
      reg     x;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_io(d[i], x);
            r[i] = x;
         end
         bit_io(m, x);
         a = !x;
      end
   endtask
   task automatic wr(input [7:0] cmd, input [15:0] d, input integer nb,
                     output ok);
      reg [7:0] r;
      reg       a;
      begin
         start;
         byte_io({ADDR, 1'b0}, 1'b1, r, ok);
         byte_io(cmd, 1'b1, r, a);
         ok = ok & a;
         if (nb > 0) byte_io(d[7:0], 1'b1, r, a);
         if (nb > 1) byte_io(d[15:8], 1'b1, r, a);
         stop;
      end
   endtask
   task automatic rd(input [7:0] cmd, input integer nb, output [15:0] d,
                     output ok);
      reg [7:0] lo;
      reg [7:0] hi;
      reg       a;
      begin
         hi = 8'h00;
         start;
         byte_io({ADDR, 1'b0}, 1'b1, lo, ok);
         byte_io(cmd, 1'b1, lo, a);
         ok = ok & a;
         start;
         byte_io({ADDR, 1'b1}, 1'b1, lo, a);
         ok = ok & a;
         byte_io(8'hFF, nb == 1, lo, a);
         if (nb > 1) byte_io(8'hFF, 1'b1, hi, a);
         d = {hi, lo};
         stop;
      end
   endtask
endmodule // smbus_host_model
